// >>> rtl/rx_pause_termination.sv
// receive pause frame classification and per-class pause handshake
//
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps

module rx_pause_termination
  import rx_pause_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // parsed frame header, one-cycle strobe
  input wire logic hdr_valid_i,
  input wire rx_hdr_t hdr_i,
  // frame verdicts, one-cycle pulses
  output logic ctl_frame_o,
  output logic ctl_fwd_o,
  output logic ctl_drop_o,
  output logic gpause_o,
  output logic ppause_o,
  // pause handshake with user logic
  output logic [8:0] pause_req_o,
  input wire logic [8:0] pause_ack_i
);

  pause_top_t s_reg;
  pause_top_t s_next;

  logic fwd_on;
  logic ack_chk;
  logic [3:0] cls_en;
  logic [3:0] uc_on;
  logic [3:0] mc_on;
  logic [3:0] sa_on;
  logic [3:0] et_on;
  logic [3:0] op_on;
  logic da_uc;
  logic da_gmc;
  logic da_pmc;
  logic sa_eq;
  logic da_match_gctl;
  logic da_match_pctl;
  logic da_match_gpause;
  logic da_match_ppause;
  logic [3:0] sa_match;
  logic [3:0] et_match;
  logic [3:0] op_match;
  logic gctl_hit;
  logic pctl_hit;
  logic ctl_hit;
  logic gpause_hit;
  logic ppause_hit;
  logic [8:0] pause_hit;
  logic [8:0][15:0] pause_q;
  logic [8:0] req_vec;
  logic [8:0] busy_vec;
  logic [7:0] word_adr;

  // control fields
  assign fwd_on = s_reg.ctrl[CTRL_FWD_BIT];
  assign ack_chk = s_reg.ctrl[CTRL_ACKCHK_BIT];
  assign cls_en = s_reg.ctrl[CTRL_EN_LSB +: 4];
  assign uc_on = s_reg.ctrl[CTRL_UC_LSB +: 4];
  assign mc_on = s_reg.ctrl[CTRL_MC_LSB +: 4];
  assign sa_on = s_reg.ctrl[CTRL_SA_LSB +: 4];
  assign et_on = s_reg.ctrl[CTRL_ET_LSB +: 4];
  assign op_on = s_reg.ctrl[CTRL_OP_LSB +: 4];
  assign word_adr = {wb_adr_i[7:2], 2'b00};

  // address comparisons shared by the classes; unicast and source by all four
  assign da_uc = (hdr_i.da == s_reg.ucast);
  assign da_gmc = (hdr_i.da == GLOBAL_PAUSE_DA);
  assign da_pmc = (hdr_i.da == s_reg.mcast);
  assign sa_eq = (hdr_i.sa == s_reg.src);

  // destination address tests per class
  assign da_match_gctl = (!mc_on[CLS_GCTL] && !uc_on[CLS_GCTL]) ||
    (da_uc && uc_on[CLS_GCTL]) || (da_gmc && mc_on[CLS_GCTL]);
  assign da_match_pctl = (!mc_on[CLS_PCTL] && !uc_on[CLS_PCTL]) ||
    (da_uc && uc_on[CLS_PCTL]) || (da_pmc && mc_on[CLS_PCTL]);
  assign da_match_gpause = (!mc_on[CLS_GPAUSE] && !uc_on[CLS_GPAUSE]) ||
    (da_uc && uc_on[CLS_GPAUSE]) || (da_gmc && mc_on[CLS_GPAUSE]);
  // the and-joined first term can never be true with the unicast term
  assign da_match_ppause = ((!mc_on[CLS_PPAUSE] && !uc_on[CLS_PPAUSE]) &&
    (da_uc && uc_on[CLS_PPAUSE])) || (da_pmc && mc_on[CLS_PPAUSE]);

  // source, ethertype and opcode tests per class
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      sa_match[c] = !sa_on[c] || sa_eq;
    end
    et_match[CLS_GCTL] = !et_on[CLS_GCTL] ||
      (hdr_i.etype == s_reg.etype_ctl[15:0]);
    et_match[CLS_PCTL] = !et_on[CLS_PCTL] ||
      (hdr_i.etype == s_reg.etype_ctl[31:16]);
    et_match[CLS_GPAUSE] = !et_on[CLS_GPAUSE] ||
      (hdr_i.etype == s_reg.etype_pause[15:0]);
    et_match[CLS_PPAUSE] = !et_on[CLS_PPAUSE] ||
      (hdr_i.etype == s_reg.etype_pause[31:16]);
    op_match[CLS_GCTL] = !op_on[CLS_GCTL] ||
      ((hdr_i.opcode >= s_reg.opc_gctl[15:0]) &&
       (hdr_i.opcode <= s_reg.opc_gctl[31:16]));
    op_match[CLS_PCTL] = !op_on[CLS_PCTL] ||
      ((hdr_i.opcode >= s_reg.opc_pctl[15:0]) &&
       (hdr_i.opcode <= s_reg.opc_pctl[31:16]));
    op_match[CLS_GPAUSE] = !op_on[CLS_GPAUSE] ||
      (hdr_i.opcode == s_reg.opc_pause[15:0]);
    op_match[CLS_PPAUSE] = !op_on[CLS_PPAUSE] ||
      (hdr_i.opcode == s_reg.opc_pause[31:16]);
  end

  // frame classification in three ordered steps
  assign gctl_hit = da_match_gctl && sa_match[CLS_GCTL] &&
    et_match[CLS_GCTL] && op_match[CLS_GCTL] && cls_en[CLS_GCTL];
  assign pctl_hit = da_match_pctl && sa_match[CLS_PCTL] &&
    et_match[CLS_PCTL] && op_match[CLS_PCTL] && cls_en[CLS_PCTL];
  assign ctl_hit = hdr_valid_i && (gctl_hit || pctl_hit);
  assign gpause_hit = ctl_hit && da_match_gpause &&
    sa_match[CLS_GPAUSE] && et_match[CLS_GPAUSE] &&
    op_match[CLS_GPAUSE] && cls_en[CLS_GPAUSE];
  assign ppause_hit = ctl_hit && !gpause_hit && da_match_ppause &&
    sa_match[CLS_PPAUSE] && et_match[CLS_PPAUSE] &&
    op_match[CLS_PPAUSE] && cls_en[CLS_PPAUSE];

  // route pause hits and quanta onto the nine classes
  always_comb begin
    for (int k = 0; k < GLOBAL_BIT; k++) begin
      pause_hit[k] = ppause_hit && hdr_i.cev[k];
      pause_q[k] = hdr_i.quanta[k];
    end
    pause_hit[GLOBAL_BIT] = gpause_hit;
    pause_q[GLOBAL_BIT] = hdr_i.quanta[0];
  end

  // status vectors gathered from the class machines
  always_comb begin
    for (int k = 0; k < NUM_CLASSES; k++) begin
      req_vec[k] = s_reg.cls[k].req;
      busy_vec[k] = (s_reg.cls[k].st != PS_IDLE);
    end
  end

  // byte-lane merge for register writes
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // next state: bus, verdict pulses and the class machines
  always_comb begin
    logic [31:0] wv;
    wv = 32'h00000000;
    s_next = s_reg;
    // wishbone: ack one cycle after the request, write on the acked edge
    s_next.ack = wb_cyc_i && wb_stb_i && !s_reg.ack;
    s_next.rdat = 32'h00000000;
    if (wb_cyc_i && wb_stb_i && !s_reg.ack && !wb_we_i) begin
      unique case (word_adr)
        CTRL_OFS: s_next.rdat = s_reg.ctrl;
        PAUSE_EN_OFS: s_next.rdat = {23'h000000, s_reg.pause_en};
        UCAST_LO_OFS: s_next.rdat = s_reg.ucast[31:0];
        UCAST_HI_OFS: s_next.rdat = {16'h0000, s_reg.ucast[47:32]};
        MCAST_LO_OFS: s_next.rdat = s_reg.mcast[31:0];
        MCAST_HI_OFS: s_next.rdat = {16'h0000, s_reg.mcast[47:32]};
        SRC_LO_OFS: s_next.rdat = s_reg.src[31:0];
        SRC_HI_OFS: s_next.rdat = {16'h0000, s_reg.src[47:32]};
        ETYPE_CTL_OFS: s_next.rdat = s_reg.etype_ctl;
        ETYPE_PAUSE_OFS: s_next.rdat = s_reg.etype_pause;
        OPC_GCTL_OFS: s_next.rdat = s_reg.opc_gctl;
        OPC_PCTL_OFS: s_next.rdat = s_reg.opc_pctl;
        OPC_PAUSE_OFS: s_next.rdat = s_reg.opc_pause;
        STATUS_OFS: s_next.rdat = {14'h0000, busy_vec, req_vec};
        default: s_next.rdat = 32'h00000000;
      endcase
    end
    if (wb_cyc_i && wb_stb_i && wb_we_i && s_reg.ack) begin
      unique case (word_adr)
        CTRL_OFS: s_next.ctrl = wmerge(s_reg.ctrl, wb_dat_i, wb_sel_i);
        PAUSE_EN_OFS: begin
          wv = wmerge({23'h000000, s_reg.pause_en}, wb_dat_i, wb_sel_i);
          s_next.pause_en = wv[8:0];
        end
        UCAST_LO_OFS: s_next.ucast[31:0] =
          wmerge(s_reg.ucast[31:0], wb_dat_i, wb_sel_i);
        UCAST_HI_OFS: begin
          wv = wmerge({16'h0000, s_reg.ucast[47:32]}, wb_dat_i, wb_sel_i);
          s_next.ucast[47:32] = wv[15:0];
        end
        MCAST_LO_OFS: s_next.mcast[31:0] =
          wmerge(s_reg.mcast[31:0], wb_dat_i, wb_sel_i);
        MCAST_HI_OFS: begin
          wv = wmerge({16'h0000, s_reg.mcast[47:32]}, wb_dat_i, wb_sel_i);
          s_next.mcast[47:32] = wv[15:0];
        end
        SRC_LO_OFS: s_next.src[31:0] =
          wmerge(s_reg.src[31:0], wb_dat_i, wb_sel_i);
        SRC_HI_OFS: begin
          wv = wmerge({16'h0000, s_reg.src[47:32]}, wb_dat_i, wb_sel_i);
          s_next.src[47:32] = wv[15:0];
        end
        ETYPE_CTL_OFS: s_next.etype_ctl =
          wmerge(s_reg.etype_ctl, wb_dat_i, wb_sel_i);
        ETYPE_PAUSE_OFS: s_next.etype_pause =
          wmerge(s_reg.etype_pause, wb_dat_i, wb_sel_i);
        OPC_GCTL_OFS: s_next.opc_gctl =
          wmerge(s_reg.opc_gctl, wb_dat_i, wb_sel_i);
        OPC_PCTL_OFS: s_next.opc_pctl =
          wmerge(s_reg.opc_pctl, wb_dat_i, wb_sel_i);
        OPC_PAUSE_OFS: s_next.opc_pause =
          wmerge(s_reg.opc_pause, wb_dat_i, wb_sel_i);
        default: s_next.ctrl = s_reg.ctrl; // read-only or unmapped
      endcase
    end
    // verdict pulses, registered one cycle after the header strobe
    s_next.ctl_pulse = ctl_hit;
    s_next.fwd_pulse = ctl_hit && fwd_on;
    s_next.drop_pulse = ctl_hit && !fwd_on;
    s_next.gpause_pulse = gpause_hit;
    s_next.ppause_pulse = ppause_hit;
    // one independent handshake machine per class
    for (int k = 0; k < NUM_CLASSES; k++) begin
      unique case (s_reg.cls[k].st)
        PS_IDLE: begin
          if (pause_hit[k] && s_reg.pause_en[k]) begin
            s_next.cls[k].req = 1'b1;
            s_next.cls[k].timer = pause_q[k];
            s_next.cls[k].st = ack_chk ? PS_WAIT_ACK : PS_COUNT;
          end
        end
        PS_WAIT_ACK: begin
          // enable is not looked at past idle
          if (pause_hit[k]) begin
            s_next.cls[k].timer = pause_q[k];
          end
          if (!ack_chk || pause_ack_i[k]) begin
            s_next.cls[k].st = PS_COUNT;
          end
        end
        PS_COUNT: begin
          if (pause_hit[k]) begin
            s_next.cls[k].timer = pause_q[k];
          end else if (s_reg.cls[k].timer == 16'h0000) begin
            s_next.cls[k].req = 1'b0;
            s_next.cls[k].fin_cnt = 6'h00;
            s_next.cls[k].st = ack_chk ? PS_FINISH : PS_IDLE;
          end else begin
            s_next.cls[k].timer =
              s_reg.cls[k].timer - QUANTA_PER_CYCLE;
          end
        end
        PS_FINISH: begin
          if (pause_hit[k]) begin
            s_next.cls[k].timer = pause_q[k];
          end
          if (!pause_ack_i[k] || s_reg.cls[k].fin_cnt == FIN_CNT_LAST) begin
            s_next.cls[k].st = PS_IDLE;
          end else begin
            s_next.cls[k].fin_cnt = s_reg.cls[k].fin_cnt + 6'h01;
          end
        end
        default: s_next.cls[k].st = PS_IDLE;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.ctrl <= CTRL_RST;
      s_reg.pause_en <= PAUSE_EN_RST;
      for (int k = 0; k < NUM_CLASSES; k++) begin
        s_reg.cls[k].st <= PS_IDLE;
      end
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state flip-flops
  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = s_reg.rdat;
  assign ctl_frame_o = s_reg.ctl_pulse;
  assign ctl_fwd_o = s_reg.fwd_pulse;
  assign ctl_drop_o = s_reg.drop_pulse;
  assign gpause_o = s_reg.gpause_pulse;
  assign ppause_o = s_reg.ppause_pulse;
  assign pause_req_o = req_vec;

  // checks on the frame verdicts
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_fwd_gate: assert property (
    ctl_hit |=> (ctl_fwd_o == $past(fwd_on)) && (ctl_drop_o != ctl_fwd_o))
    else $error("control frame forwarding does not follow setting");
  chk_class_order: assert property (
    (gpause_o || ppause_o) |-> ctl_frame_o && !(gpause_o && ppause_o))
    else $error("pause verdict without control verdict or both kinds");
  chk_gctl_dest: assert property (
    (mc_on[CLS_GCTL] && !uc_on[CLS_GCTL] && !da_gmc) |-> !da_match_gctl)
    else $error("global control address matched a foreign address");

  // checks on each class machine
  for (genvar g = 0; g < NUM_CLASSES; g++) begin : g_chk
    sequence seq_idle_take;
      s_reg.cls[g].st == PS_IDLE && pause_hit[g];
    endsequence
    sequence seq_count_run;
      s_reg.cls[g].st == PS_COUNT && !pause_hit[g] &&
        s_reg.cls[g].timer != 16'h0000;
    endsequence
    sequence seq_finish_stuck;
      s_reg.cls[g].st == PS_FINISH && pause_ack_i[g] && !pause_hit[g];
    endsequence

    chk_idle_load: assert property (
      seq_idle_take |=> s_reg.cls[g].req == $past(s_reg.pause_en[g]) &&
        (!s_reg.cls[g].req || s_reg.cls[g].timer == $past(pause_q[g])))
      else $error("pause request or timer load wrong from idle");
    chk_wait_hold: assert property (
      (s_reg.cls[g].st == PS_WAIT_ACK && ack_chk && !pause_ack_i[g] &&
       !pause_hit[g]) |=> s_reg.cls[g].st == PS_WAIT_ACK &&
        $stable(s_reg.cls[g].timer) && s_reg.cls[g].req)
      else $error("timer moved or wait left without ack");
    chk_count_down: assert property (
      seq_count_run |=> s_reg.cls[g].timer ==
        $past(s_reg.cls[g].timer) - 16'h0001)
      else $error("pause timer did not count down by one");
    chk_expire_drop: assert property (
      (s_reg.cls[g].st == PS_COUNT && !pause_hit[g] &&
       s_reg.cls[g].timer == 16'h0000) |=> !s_reg.cls[g].req)
      else $error("request still high after timer expiry");
    chk_finish_bound: assert property (
      seq_finish_stuck [*8] |-> ##[1:25] s_reg.cls[g].st == PS_IDLE)
      else $error("unreturned ack kept class busy too long");
    chk_reload_quanta: assert property (
      (s_reg.cls[g].st != PS_IDLE && pause_hit[g]) |=>
        s_reg.cls[g].timer == $past(pause_q[g]) &&
        (s_reg.cls[g].st != PS_IDLE ||
         $past(s_reg.cls[g].st == PS_FINISH)))
      else $error("new pause did not reload the timer");
  end

endmodule : rx_pause_termination

// >>> rtl/rx_pause_pkg.sv
// constants, register map and carrier types for receive pause termination
package rx_pause_pkg;

  // fixed global pause destination address
  localparam logic [47:0] GLOBAL_PAUSE_DA = 48'h0180C2000001;

  // cycles after a dropped request before an unreturned ack is given up
  localparam int FINISH_CYCLES = 32;
  localparam logic [5:0] FIN_CNT_LAST = 6'(FINISH_CYCLES - 1);

  // pause timer falls by one quanta per clock cycle
  localparam logic [15:0] QUANTA_PER_CYCLE = 16'h0001;

  // class-bus layout: global pause on the top bit
  localparam int NUM_CLASSES = 9;
  localparam int GLOBAL_BIT = 8;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PAUSE_EN_OFS = 8'h04;
  localparam logic [7:0] UCAST_LO_OFS = 8'h08;
  localparam logic [7:0] UCAST_HI_OFS = 8'h0C;
  localparam logic [7:0] MCAST_LO_OFS = 8'h10;
  localparam logic [7:0] MCAST_HI_OFS = 8'h14;
  localparam logic [7:0] SRC_LO_OFS = 8'h18;
  localparam logic [7:0] SRC_HI_OFS = 8'h1C;
  localparam logic [7:0] ETYPE_CTL_OFS = 8'h20;
  localparam logic [7:0] ETYPE_PAUSE_OFS = 8'h24;
  localparam logic [7:0] OPC_GCTL_OFS = 8'h28;
  localparam logic [7:0] OPC_PCTL_OFS = 8'h2C;
  localparam logic [7:0] OPC_PAUSE_OFS = 8'h30;
  localparam logic [7:0] STATUS_OFS = 8'h34;

  // control register fields; each check group is four bits wide,
  // one per class in the order below
  localparam int CTRL_FWD_BIT = 0;
  localparam int CTRL_ACKCHK_BIT = 1;
  localparam int CTRL_EN_LSB = 2;
  localparam int CTRL_UC_LSB = 6;
  localparam int CTRL_MC_LSB = 10;
  localparam int CTRL_SA_LSB = 14;
  localparam int CTRL_ET_LSB = 18;
  localparam int CTRL_OP_LSB = 22;
  localparam int CLS_GCTL = 0;
  localparam int CLS_PCTL = 1;
  localparam int CLS_GPAUSE = 2;
  localparam int CLS_PPAUSE = 3;
  localparam int STATUS_BUSY_LSB = 9;

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000003C;
  localparam logic [8:0] PAUSE_EN_RST = 9'h1FF;

  // parsed header of one received frame
  typedef struct packed {
    logic [47:0] da;
    logic [47:0] sa;
    logic [15:0] etype;
    logic [15:0] opcode;
    logic [7:0] cev;
    logic [7:0][15:0] quanta;
  } rx_hdr_t;

  // per-class handshake steps
  typedef enum logic [3:0] {
    PS_IDLE = 4'b0001,
    PS_WAIT_ACK = 4'b0010,
    PS_COUNT = 4'b0100,
    PS_FINISH = 4'b1000
  } pause_state_t;

  typedef struct packed {
    pause_state_t st;
    logic [15:0] timer;
    logic [5:0] fin_cnt;
    logic req;
  } pause_class_t;

  // whole state of the block
  typedef struct packed {
    logic [31:0] ctrl;
    logic [8:0] pause_en;
    logic [47:0] ucast;
    logic [47:0] mcast;
    logic [47:0] src;
    logic [31:0] etype_ctl;
    logic [31:0] etype_pause;
    logic [31:0] opc_gctl;
    logic [31:0] opc_pctl;
    logic [31:0] opc_pause;
    logic ack;
    logic [31:0] rdat;
    logic ctl_pulse;
    logic fwd_pulse;
    logic drop_pulse;
    logic gpause_pulse;
    logic ppause_pulse;
    pause_class_t [8:0] cls;
  } pause_top_t;

endpackage : rx_pause_pkg

// >>> verification/pause_user_model.sv
// user flow-control model answering pause requests
`timescale 1ns/1ps
module pause_user_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // behaviour controls: answer delay, keep ack high after release
  input wire logic [3:0] delay_i,
  input wire logic hold_i,
  // pause handshake
  input wire logic [8:0] pause_req_i,
  output logic [8:0] pause_ack_o
);
  logic [8:0][3:0] wait_reg;

  // per class: ack after delay_i cycles of request, drop after release unless hold_i
  always_ff @(posedge clk_i) begin
    for (int k = 0; k < 9; k++) begin
      if (rst_i || !pause_req_i[k]) begin
        wait_reg[k] <= 4'h0;
      end else if (wait_reg[k] != delay_i) begin
        wait_reg[k] <= wait_reg[k] + 4'h1;
      end
      if (rst_i) begin
        pause_ack_o[k] <= 1'b0;
      end else if (pause_req_i[k] && wait_reg[k] == delay_i) begin
        pause_ack_o[k] <= 1'b1;
      end else if (!pause_req_i[k] && !hold_i) begin
        pause_ack_o[k] <= 1'b0;
      end
    end
  end
endmodule : pause_user_model

// >>> verification/tb.sv
// self-checking bench for receive pause termination
`timescale 1ns/1ps
module tb;
  import rx_pause_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dw = 32'h0;
  logic [31:0] dr;
  logic ack;
  logic hv = 1'b0;
  rx_hdr_t hdr = '0;
  logic ctl_frame, fwd, drop, gp, pp;
  logic [8:0] req;
  logic [8:0] uack;
  logic [3:0] dly = 4'h0;
  logic hold = 1'b0;
  logic [31:0] r;
  logic [4:0] v;
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int hi[9];

  always #50 clk_i = ~clk_i;

  rx_pause_termination DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
    .wb_dat_o(dr), .wb_ack_o(ack), .hdr_valid_i(hv), .hdr_i(hdr),
    .ctl_frame_o(ctl_frame), .ctl_fwd_o(fwd), .ctl_drop_o(drop),
    .gpause_o(gp), .ppause_o(pp), .pause_req_o(req), .pause_ack_i(uack)
  );

  pause_user_model user (
    .clk_i(clk_i), .rst_i(rst_i), .delay_i(dly), .hold_i(hold),
    .pause_req_i(req), .pause_ack_o(uack)
  );

  // count request-high cycles per class
  always @(negedge clk_i) begin
    for (int k = 0; k < 9; k++) begin
      hi[k] = hi[k] + int'(req[k] === 1'b1);
    end
  end

  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      $display("BAD %0t timeout", $time);
      finish_test;
    end
  end

  task finish_test;
    if (err_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    sel <= 4'hF;
    do @(posedge clk_i); while (ack !== 1'b1);
    r = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task send(input logic [47:0] da, input logic [15:0] op,
            input logic [7:0] cev, input logic [15:0] q0,
            input logic [15:0] q2, input bit keep);
    @(posedge clk_i);
    if (!keep) begin
      foreach (hi[k]) hi[k] = 0;
    end
    hdr.da <= da;
    hdr.opcode <= op;
    hdr.cev <= cev;
    hdr.quanta[0] <= q0;
    hdr.quanta[2] <= q2;
    hv <= 1'b1;
    @(posedge clk_i);
    hv <= 1'b0;
    @(negedge clk_i);
    v = {ctl_frame, fwd, drop, gp, pp};
  endtask : send

  task wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt

  // main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, CTRL_OFS, 32'h0); chk(r, CTRL_RST);
    wb(1'b0, PAUSE_EN_OFS, 32'h0); chk(r, 32'h1FF);
    wb(1'b0, 8'h3C, 32'h0); chk(r, 32'h0);
    // plain global pause, consumed, no ack checking
    send(48'h0, 16'h0, 8'h0, 16'h3, 16'h0, 0); chk(v, 5'b10110);
    wt(30); chk(hi[8], 4);
    // forwarding and reload during countdown
    wb(1'b1, CTRL_OFS, 32'h3D);
    send(48'h0, 16'h0, 8'h0, 16'h5, 16'h0, 0);
    send(48'h0, 16'h0, 8'h0, 16'h5, 16'h0, 1); chk(v, 5'b11010);
    wt(30); chk(hi[8], 8);
    // fixed multicast destination check, priority control disabled
    wb(1'b1, CTRL_OFS, 32'h1434);
    send(48'h112233445566, 16'h0, 8'h0, 16'h3, 16'h0, 0); chk(v, 0);
    wt(20); chk(hi[8], 0);
    send(GLOBAL_PAUSE_DA, 16'h0, 8'h0, 16'h3, 16'h0, 0); chk(v, 5'b10110);
    wt(20); chk(hi[8], 4);
    // priority pause after global opcode mismatch
    wb(1'b1, MCAST_LO_OFS, 32'h33445566);
    wb(1'b1, MCAST_HI_OFS, 32'h00000112);
    wb(1'b1, OPC_PAUSE_OFS, 32'h01010001);
    wb(1'b1, CTRL_OFS, 32'h0100203C);
    send(48'h011233445566, 16'h0101, 8'h05, 16'h2, 16'h4, 0); chk(v, 5'b10101);
    wt(20); chk(hi[0], 3);
    chk(hi[1], 0);
    chk(hi[2], 5);
    chk(hi[8], 0);
    send(GLOBAL_PAUSE_DA, 16'h0101, 8'h05, 16'h2, 16'h4, 0); chk(v, 5'b10100);
    // destination checks both off: printed form rejects
    wb(1'b1, CTRL_OFS, 32'h0100003C);
    send(48'h011233445566, 16'h0101, 8'h05, 16'h2, 16'h4, 0); chk(v, 5'b10100);
    // ack checking with a slow user
    wb(1'b1, CTRL_OFS, 32'h3E);
    dly <= 4'h3;
    send(48'h0, 16'h0, 8'h0, 16'h2, 16'h0, 0);
    wt(30); chk(hi[8], 8);
    wb(1'b0, STATUS_OFS, 32'h0); chk(r, 32'h0);
    // user never returns ack: give-up after the finish count
    dly <= 4'h0;
    hold <= 1'b1;
    send(48'h0, 16'h0, 8'h0, 16'h1, 16'h0, 0);
    wt(8); chk(hi[8], 4);
    wb(1'b0, STATUS_OFS, 32'h0); chk(r, 32'h00020000);
    wt(20);
    wb(1'b0, STATUS_OFS, 32'h0); chk(r, 32'h00020000);
    wt(40);
    wb(1'b0, STATUS_OFS, 32'h0); chk(r, 32'h0);
    hold <= 1'b0;
    // disabled class ignores pause; disabling mid-run finishes normally
    wb(1'b1, CTRL_OFS, 32'h3C);
    wb(1'b1, PAUSE_EN_OFS, 32'hFF);
    send(48'h0, 16'h0, 8'h0, 16'h3, 16'h0, 0); chk(v, 5'b10110);
    wt(20); chk(hi[8], 0);
    wb(1'b1, PAUSE_EN_OFS, 32'h1FF);
    send(48'h0, 16'h0, 8'h0, 16'h14, 16'h0, 0);
    wb(1'b1, PAUSE_EN_OFS, 32'h0);
    wt(30); chk(hi[8], 21);
    // control opcode range, source and ethertype checks, global class
    wb(1'b1, OPC_GCTL_OFS, 32'h00100008);
    wb(1'b1, CTRL_OFS, 32'h00400034);
    send(48'h0, 16'h0008, 8'h0, 16'h1, 16'h0, 0); chk(v, 5'b10110);
    send(48'h0, 16'h0010, 8'h0, 16'h1, 16'h0, 0); chk(v, 5'b10110);
    send(48'h0, 16'h0011, 8'h0, 16'h1, 16'h0, 0); chk(v, 0);
    send(48'h0, 16'h0007, 8'h0, 16'h1, 16'h0, 0); chk(v, 0);
    wb(1'b1, SRC_LO_OFS, 32'h00000001);
    wb(1'b1, CTRL_OFS, 32'h00404034);
    send(48'h0, 16'h0008, 8'h0, 16'h1, 16'h0, 0); chk(v, 0);
    wb(1'b1, SRC_LO_OFS, 32'h00000000);
    send(48'h0, 16'h0008, 8'h0, 16'h1, 16'h0, 0); chk(v, 5'b10110);
    wb(1'b1, ETYPE_CTL_OFS, 32'h00000001);
    wb(1'b1, CTRL_OFS, 32'h00444034);
    send(48'h0, 16'h0008, 8'h0, 16'h1, 16'h0, 0); chk(v, 0);
    wb(1'b1, STATUS_OFS, 32'hFFFFFFFF);
    wb(1'b0, STATUS_OFS, 32'h0); chk(r, 32'h0);
    finish_test;
  end
endmodule : tb
